// ### hdl/op_classify.sv
`timescale 1ns/10ps
// Opcode class and word count of one instruction word
`include "xdec_map.svh"
module op_classify (
  // Instruction word
  input  wire logic [15:0]    word,
  input  wire logic           extEn,
  // Decode result
  output xdec_pkg::op_class_t opClass,
  output logic                twoWord
);
  import xdec_pkg::*;

  // Extended codes fall back to no-operation while the set is off
  always_comb begin
    opClass = OP_NOP;
    casez (word)
      `OPC_TSTSKIP:  opClass = OP_TSTSKIP;
      `OPC_XORLIT:   opClass = OP_XORLIT;
      `OPC_XORREG:   opClass = OP_XORREG;
      `OPC_ADDPTR:   opClass = extEn ? OP_ADDPTR : OP_NOP;
      `OPC_SUBPTR:   opClass = extEn ? OP_SUBPTR : OP_NOP;
      `OPC_PUSHLIT:  opClass = extEn ? OP_PUSHLIT : OP_NOP;
      `OPC_MOVIDX:   opClass = extEn ? OP_MOVIDX : OP_NOP;
      `OPC_CALLWORK: opClass = extEn ? OP_CALLWORK : OP_NOP;
      default:       opClass = OP_NOP;
    endcase
  end

  assign twoWord = (opClass == OP_MOVIDX);
endmodule

// ### hdl/xdec_map.svh
// Offsets, field positions, reset values and cycle counts of the extended decode block
`ifndef XDEC_MAP_SVH
`define XDEC_MAP_SVH
`define Q_PHASES     4
`define AXI_AW       8
`define REG_CTRL     8'h00
`define REG_STATUS   8'h04
`define REG_WORK     8'h08
`define REG_BANK     8'h0C
`define REG_PTR0     8'h10
`define REG_PTR1     8'h14
`define REG_PTR2     8'h18
`define REG_LATCH    8'h1C
`define REG_PC       8'h20
`define CTRL_EXT     0
`define CTRL_RUN     1
`define CTRL_RST     2'h0
`define STAT_Z       0
`define STAT_N       1
`define STAT_ST_LSB  4
`define LATCH_UP_LSB 8
`define RESP_OK      2'h0
`define RESP_ERR     2'h2
`define IDX_MAX      8'h5F
`define ACC_SPLIT    8'h60
`define NOP_WORD     16'h0000
`define OPC_TSTSKIP  16'b011?_0110_????_????
`define OPC_XORLIT   16'b0000_1010_????_????
`define OPC_XORREG   16'b0001_10??_????_????
`define OPC_ADDPTR   16'b1110_1000_????_????
`define OPC_SUBPTR   16'b1110_1001_????_????
`define OPC_PUSHLIT  16'b1110_1010_????_????
`define OPC_MOVIDX   16'b1110_1011_????_????
`define OPC_CALLWORK 16'b0000_0000_0001_0100
`endif

// ### hdl/xdec_pkg.sv
// Types shared by the extended decode block
package xdec_pkg;
  typedef enum logic [3:0] {
    ST_EXEC   = 4'b0001,
    ST_FLUSH  = 4'b0010,
    ST_FLUSH2 = 4'b0100,
    ST_WORD2  = 4'b1000
  } exec_state_t;
  typedef enum logic [3:0] {
    OP_NOP, OP_TSTSKIP, OP_XORLIT, OP_XORREG, OP_ADDPTR,
    OP_SUBPTR, OP_CALLWORK, OP_MOVIDX, OP_PUSHLIT
  } op_class_t;
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic        we;
  } dmem_req_t;
  typedef struct packed {
    logic        push;
    logic        pop;
    logic [20:0] retAddr;
  } rstack_req_t;
endpackage

// ### hdl/xor_test_and_indexed_ext_decode.sv
// Design decisions made here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/10ps
// Decode and execute of skip, XOR and extended indexed instructions
//
// Contract
// - Skip on zero register discards fetched word and idles one cycle.
// - Skip over a two-word instruction idles two cycles, three in total.
// - Access bit 0 selects fixed access bank, 1 selects bank register.
// - Access 0, extended on, field up to 5Fh: offset from stack pointer.
// - XOR literal into work register in one cycle, updating N and Z.
// - XOR work with register; destination bit picks work or register; N, Z.
// - Extended features stay off until the configuration bit is set.
// - Eight extended instructions exist, none of which touch the flags.
// - Field 11 adds to stack pointer then returns from top of stack, two cycles.
// - Subtract 6-bit literal from pointer chosen by field, one cycle.
// - Field 11 subtracts from stack pointer then returns, two cycles.
// - Call through work register is one word, two cycles.
// - Indexed-to-absolute move: two words, source offset then 12-bit address.
// - Indexed-to-indexed move: two words, source offset then destination offset.
// - Push literal writes at stack pointer then decrements it, one cycle.
// - Call pushes return address, loads work into low byte, latches into high.
// - Indexed move addresses are stack pointer plus 7-bit offset, 12-bit space.
// - Indirect source reads 00h; indirect destination makes the indexed-to-indexed move idle.
`include "xdec_map.svh"
module xor_test_and_indexed_ext_decode #(
  parameter logic [11:0] INDIR_LO = 12'hFE0,
  parameter logic [11:0] INDIR_HI = 12'hFEF
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rstn,
  // AXI4-Lite register slave
  input  wire logic [`AXI_AW-1:0]    awaddr,
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  input  wire logic                  wvalid,
  output logic                       wready,
  output logic [1:0]                 bresp,
  output logic                       bvalid,
  input  wire logic                  bready,
  input  wire logic [`AXI_AW-1:0]    araddr,
  input  wire logic                  arvalid,
  output logic                       arready,
  output logic [31:0]                rdata,
  output logic [1:0]                 rresp,
  output logic                       rvalid,
  input  wire logic                  rready,
  // Program fetch
  output logic [20:0]                fetchAddr,
  input  wire logic [15:0]           fetchWord,
  input  wire logic                  fetchTwoWord,
  // Data memory
  output xdec_pkg::dmem_req_t        dmemReq,
  input  wire logic [7:0]            dmemRdata,
  // Return stack
  output xdec_pkg::rstack_req_t      rstackReq,
  input  wire logic [20:0]           topOfReturnStack
);
  import xdec_pkg::*;

  localparam logic [1:0] QLAST = 2'(`Q_PHASES - 1);

  logic [1:0]  qPh_r;
  logic        extEn_r, run_r, movMode_r;
  logic [15:0] ir_r;
  logic [20:0] pc_r;
  logic [7:0]  work_r, opnd_r, latchHi_r, fld, xRes;
  logic [4:0]  latchUp_r;
  logic [3:0]  bank_r;
  logic [11:0] ptr0_r, ptr1_r, ptr2_r, idxAddr, movIdx, fileAddr, memAddr;
  logic [11:0] ptrOld, ptrNew;
  logic [1:0]  ptrSel;
  logic        flagN_r, flagZ_r, useIdx, isIndir, memWr, isRet, nextTwo, nextTwoOwn;
  logic [7:0]  memWdata;
  exec_state_t state_r;
  op_class_t   opClass, curOp;
  logic        addrEdge, readEdge, commit;
  logic        awHeld_r, wHeld_r, wrFire, rdErr;
  logic [7:0]  awAddr_r;
  logic [31:0] wData_r, rdMux, wrMerged;
  logic [3:0]  wStrb_r;

  op_classify u_curDecode (
    .word    (ir_r),
    .extEn   (extEn_r),
    .opClass (opClass),
    .twoWord ()
  );

  op_classify u_nextDecode (
    .word    (fetchWord),
    .extEn   (extEn_r),
    .opClass (),
    .twoWord (nextTwoOwn)
  );

  // Four-phase instruction cycle, halted while run is clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      qPh_r <= 2'h0;
    end else if (run_r) begin
      qPh_r <= (qPh_r == QLAST) ? 2'h0 : qPh_r + 2'h1;
    end
  end

  assign addrEdge = run_r && (qPh_r == 2'h0);
  assign readEdge = run_r && (qPh_r == 2'h2);
  assign commit   = run_r && (qPh_r == QLAST);
  assign curOp    = (state_r == ST_EXEC) ? opClass : OP_NOP;
  assign fld      = ir_r[7:0];
  assign nextTwo  = fetchTwoWord || nextTwoOwn;
  assign ptrSel   = (ir_r[7:6] == 2'h3) ? 2'h2 : ir_r[7:6];
  assign isRet    = ((curOp == OP_ADDPTR) || (curOp == OP_SUBPTR)) && (ir_r[7:6] == 2'h3);
  assign isIndir  = (dmemReq.addr >= INDIR_LO) && (dmemReq.addr <= INDIR_HI);

  // Operand address for the current cycle
  always_comb begin
    useIdx  = extEn_r && !ir_r[8] && (fld <= `IDX_MAX);
    idxAddr = ptr2_r + {4'h0, fld};
    movIdx  = ptr2_r + {5'h0, ir_r[6:0]};
    if (ir_r[8]) begin
      fileAddr = {bank_r, fld};
    end else if (useIdx) begin
      fileAddr = idxAddr;
    end else if (fld < `ACC_SPLIT) begin
      fileAddr = {4'h0, fld};
    end else begin
      fileAddr = {4'hF, fld};
    end
    if (state_r == ST_WORD2) begin
      memAddr = movMode_r ? movIdx : ir_r[11:0];
    end else if (curOp == OP_MOVIDX) begin
      memAddr = movIdx;
    end else if (curOp == OP_PUSHLIT) begin
      memAddr = ptr2_r;
    end else begin
      memAddr = fileAddr;
    end
  end

  // Write decision taken at the read edge, so read data is fresh
  always_comb begin
    memWr    = 1'b0;
    memWdata = 8'h00;
    if (curOp == OP_XORREG && ir_r[9]) begin
      memWr    = 1'b1;
      memWdata = work_r ^ dmemRdata;
    end else if (curOp == OP_PUSHLIT) begin
      memWr    = 1'b1;
      memWdata = fld;
    end else if (state_r == ST_WORD2) begin
      memWr    = !(movMode_r && isIndir);
      memWdata = opnd_r;
    end
  end

  // Data memory: address in Q1, read at end of Q3, write strobe in Q4
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dmemReq <= '0;
    end else if (addrEdge) begin
      dmemReq.addr <= memAddr;
    end else if (readEdge) begin
      dmemReq.we    <= memWr;
      dmemReq.wdata <= memWdata;
    end else if (commit) begin
      dmemReq.we <= 1'b0;
    end
  end

  // Operand latch; held across the second word of a move
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      opnd_r <= 8'h00;
    end else if (readEdge && state_r == ST_EXEC) begin
      opnd_r <= (curOp == OP_MOVIDX && isIndir) ? 8'h00 : dmemRdata;
    end
  end

  assign xRes = (curOp == OP_XORLIT) ? (work_r ^ fld) : (work_r ^ opnd_r);

  // Sequencing of skips, returns and two-word moves
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r   <= ST_EXEC;
      movMode_r <= 1'b0;
    end else if (commit) begin
      unique case (state_r)
        ST_EXEC: begin
          if (curOp == OP_TSTSKIP && opnd_r == 8'h00) begin
            state_r <= nextTwo ? ST_FLUSH2 : ST_FLUSH;
          end else if (isRet || curOp == OP_CALLWORK) begin
            state_r <= ST_FLUSH;
          end else if (curOp == OP_MOVIDX) begin
            state_r   <= ST_WORD2;
            movMode_r <= ir_r[7];
          end
        end
        ST_FLUSH2: state_r <= ST_FLUSH;
        ST_FLUSH:  state_r <= ST_EXEC;
        ST_WORD2:  state_r <= ST_EXEC;
      endcase
    end
  end

  // Program counter, instruction register and return stack requests
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pc_r      <= 21'h0;
      ir_r      <= `NOP_WORD;
      rstackReq <= '0;
    end else begin
      rstackReq.push <= 1'b0;
      rstackReq.pop  <= 1'b0;
      if (commit) begin
        ir_r <= fetchWord;
        if (isRet) begin
          pc_r          <= topOfReturnStack;
          rstackReq.pop <= 1'b1;
        end else if (curOp == OP_CALLWORK) begin
          pc_r              <= {latchUp_r, latchHi_r, work_r};
          rstackReq.push    <= 1'b1;
          rstackReq.retAddr <= pc_r;
        end else begin
          pc_r <= pc_r + 21'h2;
        end
      end
    end
  end

  assign fetchAddr = pc_r;

  // Pointer arithmetic
  always_comb begin
    ptrOld = (ptrSel == 2'h0) ? ptr0_r : (ptrSel == 2'h1) ? ptr1_r : ptr2_r;
    ptrNew = (curOp == OP_SUBPTR) ? ptrOld - {6'h0, ir_r[5:0]} : ptrOld + {6'h0, ir_r[5:0]};
  end

  // Software byte-lane merge
  always_comb begin
    wrMerged = rdMux;
    for (int i = 0; i < 4; i++) begin
      if (wStrb_r[i]) begin
        wrMerged[8*i +: 8] = wData_r[8*i +: 8];
      end
    end
  end

  // Pointers: core update wins over a software write
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ptr0_r <= 12'h0;
      ptr1_r <= 12'h0;
      ptr2_r <= 12'h0;
    end else if (commit && (curOp == OP_ADDPTR || curOp == OP_SUBPTR)) begin
      if (ptrSel == 2'h0) ptr0_r <= ptrNew;
      else if (ptrSel == 2'h1) ptr1_r <= ptrNew;
      else ptr2_r <= ptrNew;
    end else if (commit && curOp == OP_PUSHLIT) begin
      ptr2_r <= ptr2_r - 12'h1;
    end else if (wrFire) begin
      if (awAddr_r == `REG_PTR0) ptr0_r <= wrMerged[11:0];
      if (awAddr_r == `REG_PTR1) ptr1_r <= wrMerged[11:0];
      if (awAddr_r == `REG_PTR2) ptr2_r <= wrMerged[11:0];
    end
  end

  // Work register and flags
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      work_r  <= 8'h00;
      flagN_r <= 1'b0;
      flagZ_r <= 1'b0;
    end else if (commit && (curOp == OP_XORLIT || curOp == OP_XORREG)) begin
      if (curOp == OP_XORLIT || !ir_r[9]) work_r <= xRes;
      flagN_r <= xRes[7];
      flagZ_r <= (xRes == 8'h00);
    end else if (wrFire && awAddr_r == `REG_WORK) begin
      work_r <= wrMerged[7:0];
    end
  end

  // Control, bank and latch registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {run_r, extEn_r} <= `CTRL_RST;
      bank_r    <= 4'h0;
      latchHi_r <= 8'h00;
      latchUp_r <= 5'h00;
    end else if (wrFire) begin
      if (awAddr_r == `REG_CTRL) begin
        extEn_r <= wrMerged[`CTRL_EXT];
        run_r   <= wrMerged[`CTRL_RUN];
      end
      if (awAddr_r == `REG_BANK) bank_r <= wrMerged[3:0];
      if (awAddr_r == `REG_LATCH) begin
        latchHi_r <= wrMerged[7:0];
        latchUp_r <= wrMerged[`LATCH_UP_LSB +: 5];
      end
    end
  end

  // Register read mux; also the old value for byte-lane merges
  always_comb begin
    rdMux = 32'h0;
    rdErr = 1'b0;
    case (rvalid ? awAddr_r : (wrFire ? awAddr_r : araddr))
      `REG_CTRL: begin
        rdMux[`CTRL_EXT] = extEn_r;
        rdMux[`CTRL_RUN] = run_r;
      end
      `REG_STATUS: begin
        rdMux[`STAT_Z] = flagZ_r;
        rdMux[`STAT_N] = flagN_r;
        rdMux[`STAT_ST_LSB +: 4] = state_r;
      end
      `REG_WORK:  rdMux[7:0]   = work_r;
      `REG_BANK:  rdMux[3:0]   = bank_r;
      `REG_PTR0:  rdMux[11:0]  = ptr0_r;
      `REG_PTR1:  rdMux[11:0]  = ptr1_r;
      `REG_PTR2:  rdMux[11:0]  = ptr2_r;
      `REG_LATCH: rdMux[12:0]  = {latchUp_r, latchHi_r};
      `REG_PC:    rdMux[20:0]  = pc_r;
      default:    rdErr        = 1'b1;
    endcase
  end

  // AXI4-Lite write: address and data in either order
  assign awready = !awHeld_r && !bvalid;
  assign wready  = !wHeld_r && !bvalid;
  assign wrFire  = awHeld_r && wHeld_r && !bvalid;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      awHeld_r <= 1'b0;
      wHeld_r  <= 1'b0;
      awAddr_r <= 8'h00;
      wData_r  <= 32'h0;
      wStrb_r  <= 4'h0;
      bvalid   <= 1'b0;
      bresp    <= `RESP_OK;
    end else begin
      if (awvalid && awready) begin
        awHeld_r <= 1'b1;
        awAddr_r <= awaddr;
      end
      if (wvalid && wready) begin
        wHeld_r <= 1'b1;
        wData_r <= wdata;
        wStrb_r <= wstrb;
      end
      if (wrFire) begin
        awHeld_r <= 1'b0;
        wHeld_r  <= 1'b0;
        bvalid   <= 1'b1;
        bresp    <= (rdErr || awAddr_r == `REG_STATUS || awAddr_r == `REG_PC) ? `RESP_ERR : `RESP_OK;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // AXI4-Lite read; held off while a write lands to share the mux
  assign arready = !rvalid && !wrFire;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0;
      rresp  <= `RESP_OK;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= rdMux;
      rresp  <= rdErr ? `RESP_ERR : `RESP_OK;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_skip_once: assert property (
    commit && curOp == OP_TSTSKIP && opnd_r == 8'h00 && !nextTwo |=> state_r == ST_FLUSH ##4 state_r == ST_EXEC)
    else $error("zero test did not idle exactly one cycle");
  a_skip_twice: assert property (
    commit && curOp == OP_TSTSKIP && opnd_r == 8'h00 && nextTwo
    |=> state_r == ST_FLUSH2 ##4 state_r == ST_FLUSH ##4 state_r == ST_EXEC)
    else $error("skip over two-word instruction not three cycles");
  a_flags_kept: assert property (
    commit && curOp != OP_XORLIT && curOp != OP_XORREG |=> $stable(flagN_r) && $stable(flagZ_r))
    else $error("flags changed by a non-XOR instruction");
  a_bank_addr: assert property (
    addrEdge && state_r == ST_EXEC && curOp == OP_XORREG && ir_r[8] |=> dmemReq.addr[11:8] == bank_r)
    else $error("bank register not used for access bit one");
  a_stack_offset: assert property (
    addrEdge && (curOp == OP_TSTSKIP || curOp == OP_XORREG) && useIdx
    |=> dmemReq.addr == $past(ptr2_r) + {4'h0, $past(fld)})
    else $error("indexed operand not offset from stack pointer");
  a_xor_lit: assert property (
    commit && curOp == OP_XORLIT
    |=> work_r == ($past(work_r) ^ $past(fld)) && flagZ_r == (work_r == 8'h00) && flagN_r == work_r[7])
    else $error("literal XOR result or zero flag wrong");
  a_ext_off: assert property (
    !extEn_r |-> opClass inside {OP_NOP, OP_TSTSKIP, OP_XORLIT, OP_XORREG})
    else $error("extended instruction decoded while disabled");
  a_ret_pop: assert property (
    commit && isRet |=> rstackReq.pop && pc_r == $past(topOfReturnStack) && state_r == ST_FLUSH)
    else $error("return after pointer arithmetic missing");
  a_call_pc: assert property (
    commit && curOp == OP_CALLWORK
    |=> rstackReq.push && pc_r[7:0] == $past(work_r) && rstackReq.retAddr == $past(pc_r))
    else $error("call through work register wrong");
  a_push_dec: assert property (
    commit && curOp == OP_PUSHLIT |=> ptr2_r == $past(ptr2_r) - 12'h1)
    else $error("push did not decrement stack pointer");
  a_move_word2: assert property (
    commit && curOp == OP_MOVIDX |=> state_r == ST_WORD2 ##4 state_r == ST_EXEC)
    else $error("indexed move not two cycles");
  a_indir_zero: assert property (
    readEdge && state_r == ST_EXEC && curOp == OP_MOVIDX && isIndir |=> opnd_r == 8'h00)
    else $error("indirect source did not read zero");

  c_skip_one: cover property (commit && curOp == OP_TSTSKIP && opnd_r == 8'h00 && !nextTwo);
  c_skip_two: cover property (commit && curOp == OP_TSTSKIP && opnd_r == 8'h00 && nextTwo);
  c_move: cover property (commit && state_r == ST_WORD2 && movMode_r);
  c_call: cover property (commit && curOp == OP_CALLWORK);
endmodule

// ### verif/test_xor_test_and_indexed_ext_decode.sv
// Self-checking bench for the skip, XOR and extended indexed decode block
`timescale 1ns/10ps
`include "xdec_map.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin nFail++; \
  $display("CHECK FAILED at %0t: got %0h expected %0h", $time, g, e); end end
module test_xor_test_and_indexed_ext_decode;
  import xdec_pkg::*;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [20:0] fetchAddr, lastRet, top_of_return_stack = 21'h0;
  logic [15:0] prog [64];
  logic        twoW [64];
  logic [7:0]  dmem [4096];
  dmem_req_t   dmemReq;
  rstack_req_t rstackReq;
  int          nFail = 0;
  int          comparisons = 0;

  always #10 clk = ~clk;

  xor_test_and_indexed_ext_decode xor_test_and_indexed_ext_decode_inst (
    .clk(clk), .rstn(rstn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .fetchAddr(fetchAddr), .fetchWord(prog[fetchAddr[6:1]]),
    .fetchTwoWord(twoW[fetchAddr[6:1]]), .dmemReq(dmemReq),
    .dmemRdata(dmem[dmemReq.addr]), .rstackReq(rstackReq), .topOfReturnStack(top_of_return_stack));

  // Data memory and return stack stand-ins
  always @(posedge clk) begin
    if (dmemReq.we) dmem[dmemReq.addr] <= dmemReq.wdata;
    if (rstackReq.push) lastRet <= rstackReq.retAddr;
  end

  task automatic tally_and_finish();
    if (nFail == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic timeout();
    nFail++;
    tally_and_finish();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (n == 40) timeout();
    `CHK(bresp, er)
    // Gap edge, so the next call never re-raises bready in this step
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n == 40) timeout();
    // Gap edge, so the next call never re-raises rready in this step
    @(posedge clk);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    `CHK(d, e)
  endtask

  // Memories cleared first so no input is unknown at time zero
  task automatic restart();
    foreach (dmem[i]) dmem[i] = 8'h00;
    foreach (prog[i]) prog[i] = `NOP_WORD;
    foreach (twoW[i]) twoW[i] = 1'b0;
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
  endtask

  // Fixed run: about fifteen instruction cycles, tail of program is no-ops
  task automatic go(input logic ext);
    wr(`REG_CTRL, {30'h0, 1'b1, ext}, `RESP_OK);
    repeat (60) @(posedge clk);
    wr(`REG_CTRL, {31'h0, ext}, `RESP_OK);
  endtask

  task automatic t_regs();
    logic [31:0] d;
    logic [1:0]  r;
    restart();
    rc(`REG_CTRL, 32'h0);
    rc(`REG_STATUS, 32'h10);
    wr(8'h40, 32'hFF, `RESP_ERR);
    wr(`REG_STATUS, 32'hFF, `RESP_ERR);
    wr(`REG_BANK, 32'hFF, `RESP_OK);
    rc(`REG_BANK, 32'hF);
    rd(8'h40, d, r);
    `CHK(r, `RESP_ERR)
    `CHK(d, 32'h0)
  endtask

  task automatic t_xorlit(input logic [7:0] w, k, ew, input logic [1:0] ef);
    logic [31:0] d;
    logic [1:0]  r;
    restart();
    wr(`REG_WORK, {24'h0, w}, `RESP_OK);
    prog[0] = {8'h0A, k};
    go(1'b0);
    rc(`REG_WORK, {24'h0, ew});
    rd(`REG_STATUS, d, r);
    `CHK(d[1:0], ef)
  endtask

  task automatic t_xorreg(input logic ext);
    logic [31:0] d;
    logic [1:0]  r;
    restart();
    dmem[12'h005] = 8'h3C;
    dmem[12'h105] = 8'h5A;
    dmem[12'h340] = 8'hF0;
    wr(`REG_WORK, 32'h0F, `RESP_OK);
    wr(`REG_BANK, 32'h3, `RESP_OK);
    wr(`REG_PTR2, 32'h100, `RESP_OK);
    prog[0] = 16'h1805;
    prog[1] = 16'h1B40;
    go(ext);
    rc(`REG_WORK, ext ? 32'h55 : 32'h33);
    `CHK(dmem[12'h340], ext ? 8'hA5 : 8'hC3)
    rd(`REG_STATUS, d, r);
    `CHK(d[1:0], 2'b10)
  endtask

  task automatic t_skip(input logic [7:0] v, input logic two, input logic [31:0] ew);
    restart();
    dmem[12'h030] = v;
    prog[0] = 16'h6630;
    prog[1] = 16'h0A55;
    twoW[1] = two;
    prog[2] = 16'h0AF0;
    prog[3] = 16'h0A0F;
    go(1'b0);
    rc(`REG_WORK, ew);
  endtask

  task automatic t_ptr(input logic ext);
    logic [31:0] d;
    logic [1:0]  r;
    restart();
    wr(`REG_PTR2, 32'h3FF, `RESP_OK);
    wr(`REG_PTR1, 32'h010, `RESP_OK);
    wr(`REG_PTR0, 32'h100, `RESP_OK);
    // Negative flag set first, so any flag change shows
    prog[0] = 16'h0A80;
    prog[1] = 16'hE8A3;
    prog[2] = 16'hE863;
    prog[3] = 16'hE923;
    prog[4] = 16'hEA08;
    go(ext);
    rd(`REG_STATUS, d, r);
    `CHK(d[1:0], 2'b10)
    rc(`REG_PTR1, ext ? 32'h033 : 32'h010);
    rc(`REG_PTR0, ext ? 32'h0DD : 32'h100);
    rc(`REG_PTR2, ext ? 32'h421 : 32'h3FF);
    `CHK(dmem[12'h422], ext ? 8'h08 : 8'h00)
  endtask

  task automatic t_ret(input logic sub);
    restart();
    wr(`REG_PTR2, 32'h100, `RESP_OK);
    top_of_return_stack <= 21'h40;
    prog[0] = sub ? 16'hE9C1 : 16'hE8C1;
    prog[1] = 16'h0A11;
    prog[32] = 16'h0A22;
    go(1'b1);
    rc(`REG_WORK, 32'h22);
    rc(`REG_PTR2, sub ? 32'h0FF : 32'h101);
  endtask

  task automatic t_call();
    restart();
    wr(`REG_WORK, 32'h20, `RESP_OK);
    wr(`REG_LATCH, 32'h10, `RESP_OK);
    prog[0] = 16'h0014;
    prog[1] = 16'h0A11;
    prog[16] = 16'h0A0F;
    go(1'b1);
    rc(`REG_WORK, 32'h2F);
    `CHK(lastRet, 21'h2)
    `CHK(fetchAddr[20:8], 13'h10)
  endtask

  task automatic t_move();
    restart();
    wr(`REG_PTR2, 32'h80, `RESP_OK);
    dmem[12'h085] = 8'h33;
    dmem[12'h0FF] = 8'h44;
    prog[0] = 16'hEB05;
    prog[1] = 16'hF123;
    prog[2] = 16'hEBFF;
    prog[3] = 16'hF086;
    go(1'b1);
    `CHK(dmem[12'h123], 8'h33)
    `CHK(dmem[12'h086], 8'h44)
    restart();
    wr(`REG_PTR2, 32'hFD0, `RESP_OK);
    dmem[12'hFE0] = 8'h55;
    dmem[12'hFE1] = 8'h66;
    dmem[12'h124] = 8'h77;
    prog[0] = 16'hEB10;
    prog[1] = 16'hF124;
    prog[2] = 16'hEB90;
    prog[3] = 16'hF011;
    go(1'b1);
    `CHK(dmem[12'h124], 8'h00)
    `CHK(dmem[12'hFE1], 8'h66)
  endtask

  initial begin
    t_regs();
    t_xorlit(8'hB5, 8'hAF, 8'h1A, 2'b00);
    t_xorlit(8'h5A, 8'h5A, 8'h00, 2'b01);
    t_xorlit(8'h01, 8'h81, 8'h80, 2'b10);
    t_xorreg(1'b0);
    t_xorreg(1'b1);
    t_skip(8'h00, 1'b0, 32'hFF);
    t_skip(8'h01, 1'b0, 32'hAA);
    t_skip(8'h00, 1'b1, 32'h0F);
    t_ptr(1'b1);
    t_ptr(1'b0);
    t_ret(1'b0);
    t_ret(1'b1);
    t_call();
    t_move();
    tally_and_finish();
  end
endmodule
